// [common/aea_pkg.sv]
// Purpose: constants and types for the active energy accumulator
// Assumes: 40 MHz clock, AHB-Lite register access, word per register
// Notes:   byte address of a register is four times its index
package aea_pkg;
   localparam int ACC_W = 49;
   localparam int ENG_W = 24;
   localparam int PWR_W = 24;
   localparam int DAT_W = 34;
   ////////////////////////////////////////////////////////////////////
   // register indices, byte address = 4 * index
   localparam logic [7:0] IDX_WAVE    = 8'h0D;
   localparam logic [7:0] IDX_NL      = 8'h0E;
   localparam logic [7:0] IDX_ACCM    = 8'h0F;
   localparam logic [7:0] IDX_GAIN    = 8'h1B;
   localparam logic [7:0] IDX_IEN_L   = 8'hD9;
   localparam logic [7:0] IDX_IEN_H   = 8'hDB;
   localparam logic [7:0] IDX_IST_L   = 8'hDC;
   localparam logic [7:0] IDX_SCALE   = 8'hE0;
   localparam logic [7:0] IDX_OFS     = 8'hE1;
   localparam logic [7:0] IDX_DIV     = 8'hE2;
   localparam logic [7:0] IDX_ENG     = 8'hE3;
   localparam logic [7:0] IDX_ENG_COR = 8'hE4;
   ////////////////////////////////////////////////////////////////////
   // field positions
   localparam int ACCM_POS    = 0;
   localparam int ACCM_ABS    = 1;
   localparam int ACCM_DIR    = 2;
   localparam int GAIN_SIGSRC = 7;
   localparam int IRQ_SIGN    = 0;
   localparam int IRQ_NOLOAD  = 1;
   localparam int IRQ_HALF    = 2;
   localparam int IRQ_OVF     = 3;
   localparam int IENH_WAVE   = 0;
   localparam int WAVE_RATE   = 2;
   localparam logic [1:0] WAVE_SRC_POWER = 2'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   ////////////////////////////////////////////////////////////////////
   // arithmetic and timing
   localparam int SCALE_FRAC = 12;
   localparam int OFS_FRAC   = 8;
   localparam logic [13:0] SCALE_ONE = 14'h1000;
   localparam int ACC_PERIOD_CYC = 5;
   localparam longint CLK_HZ  = 40000000;
   localparam longint WAVE_HZ = 27900;
   localparam int WAVE_BASE_CYC = int'(CLK_HZ / WAVE_HZ);
   localparam longint FULL_SCALE = 64'h7FFFFF;
   localparam longint PPM = 1000000;
   localparam longint NL_PPM_1 = 150;
   localparam longint NL_PPM_2 = 75;
   localparam longint NL_PPM_3 = 37;
   localparam logic [25:0] NL_THR_1 = 26'(FULL_SCALE * NL_PPM_1 / PPM);
   localparam logic [25:0] NL_THR_2 = 26'(FULL_SCALE * NL_PPM_2 / PPM);
   localparam logic [25:0] NL_THR_3 = 26'(FULL_SCALE * NL_PPM_3 / PPM);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] idx;
   } aea_bus_req_type;
endpackage : aea_pkg

// [core/aea_core.sv]
// Purpose: active power trim, sign and no-load detect, energy integrate
// Assumes: power_i is filtered active power, same clock, two's complement
// Notes:   AHB-Lite slave, zero wait states, OKAY only
//
// Summary of operation
// - power is scaled by one plus the signed 12-bit trim over 4096
// - trim 0x7FF gives about +50 %, 0x800 gives -50 %
// - a signed 16-bit offset trim is added to the power
// - offset weight is 1/256 of a power sample LSB
// - a config bit picks sign check on filtered power or per pulse
// - sign change sets a flag; enabled flag holds interrupt until cleared
// - direction bit clear flags pos-to-neg, set flags neg-to-pos
// - below no-load threshold nothing accumulates and a flag is set
// - enabled no-load flag holds interrupt until software clears it
// - two-bit threshold code: off, 0.015, 0.0075, 0.0037 % of full scale
// - 49-bit signed accumulator, only upper 24 bits readable
// - one power sample added every five clock cycles
// - both mode bits clear accumulate signed power
// - both mode bits set behave as positive-only
// - positive-only mode discards negative samples
// - magnitude mode adds absolute value of each sample
// - power divided by 8-bit divider, zero acts as one
// - clear-on-read returns energy then clears upper 24 bits
// - energy wraps around in two's complement both ways
// - flags for half-full and overflow or underflow raise interrupt
// - power waveform samples at 27.9, 14, 7 or 3.5 kSPS when enabled
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module aea_core #(
   parameter int WAVE_BASE_CYC = aea_pkg::WAVE_BASE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic [23:0] power_i,
   input  wire logic        frequency_output_pulse_i,
   output logic             irq_o,
   output logic [23:0]      wave_data_o,
   output logic             wave_strobe_o
);
   localparam int AW = aea_pkg::ACC_W;
   localparam int DW = aea_pkg::DAT_W;

   function automatic logic [DW-1:0] mag(input logic [DW-1:0] v);
      mag = v[DW-1] ? DW'(-v) : v;
   endfunction : mag

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]       wave_sel_reg;
   logic [7:0]       nl_mode_reg;
   logic [7:0]       accm_reg;
   logic [7:0]       gain_cfg_reg;
   logic [7:0]       ien_l_reg;
   logic [7:0]       ien_h_reg;
   logic [3:0]       ist_reg;
   logic [11:0]      scale_reg;
   logic [15:0]      ofs_reg;
   logic [7:0]       div_reg;
   logic [AW-1:0]    acc_reg;
   logic [31:0]      rdata_reg;
   logic             irq_reg;
   logic [2:0]       tick_cnt_reg;
   logic             prev_neg_reg;
   logic [15:0]      wave_cnt_reg;
   logic [23:0]      wave_data_reg;
   logic             wave_stb_reg;
   aea_pkg::aea_bus_req_type req_reg;
   aea_pkg::aea_bus_req_type req_next;

   ////////////////////////////////////////////////////////////////////
   // bus address phase
   logic take;
   logic cor_rd;
   assign take = hsel_i & hready_i & htrans_i[1];
   always_comb
   begin
      req_next.wr  = take & hwrite_i;
      req_next.rd  = take & ~hwrite_i;
      req_next.idx = haddr_i[9:2];
   end
   assign cor_rd = req_next.rd && req_next.idx == aea_pkg::IDX_ENG_COR;
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = rdata_reg;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         req_reg <= '0;
      else
         req_reg <= req_next;
   end

   ////////////////////////////////////////////////////////////////////
   // datapath
   logic               tick;
   logic signed [13:0] gain_f;
   logic signed [37:0] prod;
   logic [25:0]        scaled;
   logic [DW-1:0]      frac;
   logic [7:0]         div_eff;
   logic [DW-1:0]      quot;
   logic [DW-1:0]      val;
   logic [25:0]        nl_thr;
   logic               noload;
   logic               pos_mode;
   logic               abs_mode;
   logic [AW-1:0]      addend;
   logic [AW-1:0]      base;
   logic [AW-1:0]      sum;
   logic               ovf_evt;
   logic               half_evt;

   assign tick = tick_cnt_reg == 3'(aea_pkg::ACC_PERIOD_CYC - 1);
   // unity gain plus signed trim, applied as a 12-bit fraction
   assign gain_f = $signed(aea_pkg::SCALE_ONE)
                 + $signed({{2{scale_reg[11]}}, scale_reg});
   assign prod   = $signed(power_i) * gain_f;
   assign scaled = prod[37:aea_pkg::SCALE_FRAC];
   // offset lives 8 bits below the sample LSB
   assign frac = {scaled, 8'h00}
               + {{(DW-16){ofs_reg[15]}}, ofs_reg};
   assign div_eff = (div_reg == 8'h00) ? 8'h01 : div_reg;
   // one-cycle combinational divide; area traded for no extra latency
   assign quot = mag(frac) / {{(DW-8){1'b0}}, div_eff};
   assign val  = frac[DW-1] ? DW'(-quot) : quot;

   always_comb
   begin
      unique case (nl_mode_reg[1:0])
         2'h1: nl_thr = aea_pkg::NL_THR_1;
         2'h2: nl_thr = aea_pkg::NL_THR_2;
         2'h3: nl_thr = aea_pkg::NL_THR_3;
         2'h0: nl_thr = 26'h0;
      endcase
   end
   logic [25:0] scaled_mag;
   assign scaled_mag = scaled[25] ? 26'(-scaled) : scaled;
   assign noload = scaled_mag < nl_thr;

   assign pos_mode = accm_reg[aea_pkg::ACCM_POS];
   assign abs_mode = accm_reg[aea_pkg::ACCM_ABS] & ~pos_mode;

   always_comb
   begin
      if (noload)
         addend = '0;
      else if (pos_mode)
         addend = val[DW-1] ? '0
                : {{(AW-DW){1'b0}}, val};
      else if (abs_mode)
         addend = {{(AW-DW){1'b0}}, mag(val)};
      else
         addend = {{(AW-DW){val[DW-1]}}, val};
   end

   // clear-on-read keeps the low bits so no fraction is lost
   assign base = cor_rd ? {24'h0, acc_reg[AW-25:0]} : acc_reg;
   assign sum  = base + addend;
   assign ovf_evt = tick & (addend[AW-1] ? (base[AW-1] & ~sum[AW-1])
                                         : (~base[AW-1] & sum[AW-1]));
   assign half_evt = tick & (sum[AW-1] ^ sum[AW-2])
                   & ~(base[AW-1] ^ base[AW-2]);

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         tick_cnt_reg <= 3'h0;
      else if (tick)
         tick_cnt_reg <= 3'h0;
      else
         tick_cnt_reg <= tick_cnt_reg + 3'h1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         acc_reg <= '0;
      else if (tick || cor_rd)
         acc_reg <= tick ? sum : base;
   end

   ////////////////////////////////////////////////////////////////////
   // sign detection
   logic sign_evt;
   logic cur_neg;
   logic sign_hit;
   assign sign_evt = gain_cfg_reg[aea_pkg::GAIN_SIGSRC]
                   ? frequency_output_pulse_i : tick;
   assign cur_neg  = scaled[25];
   assign sign_hit = sign_evt & (accm_reg[aea_pkg::ACCM_DIR]
                   ? (prev_neg_reg & ~cur_neg)
                   : (~prev_neg_reg & cur_neg));

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         prev_neg_reg <= 1'b0;
      else if (sign_evt)
         prev_neg_reg <= cur_neg;
   end

   ////////////////////////////////////////////////////////////////////
   // status flags, set wins over write-one-to-clear
   logic [3:0] ist_set;
   logic [3:0] ist_clr;
   always_comb
   begin
      ist_set = 4'h0;
      ist_set[aea_pkg::IRQ_SIGN]   = sign_hit;
      ist_set[aea_pkg::IRQ_NOLOAD] = tick & noload
                                   & (nl_mode_reg[1:0] != 2'h0);
      ist_set[aea_pkg::IRQ_HALF]   = half_evt;
      ist_set[aea_pkg::IRQ_OVF]    = ovf_evt;
   end
   assign ist_clr = (req_reg.wr && req_reg.idx == aea_pkg::IDX_IST_L)
                  ? hwdata_i[3:0] : 4'h0;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ist_reg <= 4'h0;
      else
         ist_reg <= (ist_reg & ~ist_clr) | ist_set;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(ist_reg & ien_l_reg[3:0]);
   end
   assign irq_o = irq_reg;

   ////////////////////////////////////////////////////////////////////
   // register writes in the data phase
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wave_sel_reg <= aea_pkg::RST_BYTE;
         nl_mode_reg  <= aea_pkg::RST_BYTE;
         accm_reg     <= aea_pkg::RST_BYTE;
         gain_cfg_reg <= aea_pkg::RST_BYTE;
         ien_l_reg    <= aea_pkg::RST_BYTE;
         ien_h_reg    <= aea_pkg::RST_BYTE;
         scale_reg    <= 12'h000;
         ofs_reg      <= 16'h0000;
         div_reg      <= 8'h00;
      end
      else if (req_reg.wr)
      begin
         unique case (req_reg.idx)
            aea_pkg::IDX_WAVE:  wave_sel_reg <= hwdata_i[7:0];
            aea_pkg::IDX_NL:    nl_mode_reg  <= hwdata_i[7:0];
            aea_pkg::IDX_ACCM:  accm_reg     <= hwdata_i[7:0];
            aea_pkg::IDX_GAIN:  gain_cfg_reg <= hwdata_i[7:0];
            aea_pkg::IDX_IEN_L: ien_l_reg    <= hwdata_i[7:0];
            aea_pkg::IDX_IEN_H: ien_h_reg    <= hwdata_i[7:0];
            aea_pkg::IDX_SCALE: scale_reg    <= hwdata_i[11:0];
            aea_pkg::IDX_OFS:   ofs_reg      <= hwdata_i[15:0];
            aea_pkg::IDX_DIV:   div_reg      <= hwdata_i[7:0];
            default:            ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data, captured at the address phase
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (req_next.idx)
         aea_pkg::IDX_WAVE:    rd_mux = {24'h0, wave_sel_reg};
         aea_pkg::IDX_NL:      rd_mux = {24'h0, nl_mode_reg};
         aea_pkg::IDX_ACCM:    rd_mux = {24'h0, accm_reg};
         aea_pkg::IDX_GAIN:    rd_mux = {24'h0, gain_cfg_reg};
         aea_pkg::IDX_IEN_L:   rd_mux = {24'h0, ien_l_reg};
         aea_pkg::IDX_IEN_H:   rd_mux = {24'h0, ien_h_reg};
         aea_pkg::IDX_IST_L:   rd_mux = {28'h0, ist_reg};
         aea_pkg::IDX_SCALE:   rd_mux = {20'h0, scale_reg};
         aea_pkg::IDX_OFS:     rd_mux = {16'h0, ofs_reg};
         aea_pkg::IDX_DIV:     rd_mux = {24'h0, div_reg};
         aea_pkg::IDX_ENG,
         aea_pkg::IDX_ENG_COR: rd_mux = {8'h0, acc_reg[AW-1:AW-24]};
         default:              rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_reg <= 32'h0;
      else if (req_next.rd)
         rdata_reg <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////
   // power waveform samples
   logic [15:0] wave_period;
   logic        wave_on;
   logic        wave_due;
   assign wave_period = 16'(WAVE_BASE_CYC)
                     << wave_sel_reg[aea_pkg::WAVE_RATE +: 2];
   assign wave_on  = ien_h_reg[aea_pkg::IENH_WAVE]
                   && wave_sel_reg[1:0] == aea_pkg::WAVE_SRC_POWER;
   assign wave_due = wave_cnt_reg >= wave_period - 16'h1;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wave_cnt_reg <= 16'h0;
      else if (!wave_on || wave_due)
         wave_cnt_reg <= 16'h0;
      else
         wave_cnt_reg <= wave_cnt_reg + 16'h1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wave_stb_reg  <= 1'b0;
         wave_data_reg <= 24'h0;
      end
      else
      begin
         wave_stb_reg <= wave_on & wave_due;
         if (wave_on && wave_due)
            wave_data_reg <= scaled[23:0];
      end
   end
   assign wave_strobe_o = wave_stb_reg;
   assign wave_data_o   = wave_data_reg;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_TICK_PERIOD: assert property (tick |=> !tick [*4] ##1 tick)
      else $error("accumulate tick not every five cycles");
   AST_NOLOAD_ZERO: assert property (tick && noload |-> addend == '0)
      else $error("energy added under no-load");
   AST_NOLOAD_FLAG: assert property (
      tick && noload && nl_mode_reg[1:0] != 2'h0
      |=> ist_reg[aea_pkg::IRQ_NOLOAD])
      else $error("no-load flag not set");
   AST_POS_ONLY: assert property (
      tick && pos_mode |-> !addend[AW-1])
      else $error("negative power added in positive-only mode");
   AST_ABS_MAG: assert property (
      tick && abs_mode && !noload
      |-> addend == {{(AW-DW){1'b0}}, quot})
      else $error("magnitude mode addend wrong");
   AST_DIV_ZERO: assert property (
      tick && div_reg == 8'h00 && accm_reg[1:0] == 2'h0 && !noload
      |-> addend == {{(AW-DW){frac[DW-1]}}, frac})
      else $error("zero divider not treated as one");
   AST_COR_CLEAR: assert property (
      cor_rd && !tick |=> acc_reg[AW-1:AW-24] == 24'h0
      && hrdata_o[23:0] == $past(acc_reg[AW-1:AW-24]))
      else $error("clear-on-read misbehaved");
   AST_SIGN_DIR: assert property (
      sign_evt && !accm_reg[aea_pkg::ACCM_DIR] && !prev_neg_reg
      && cur_neg |=> ist_reg[aea_pkg::IRQ_SIGN])
      else $error("sign change flag not set");
   AST_IRQ_HOLD: assert property (
      ist_reg[aea_pkg::IRQ_SIGN] && ien_l_reg[aea_pkg::IRQ_SIGN]
      |=> irq_o)
      else $error("pending interrupt dropped");

   COV_NOLOAD: cover property (tick && noload ##5 tick && !noload);
   COV_OVF:    cover property (ovf_evt);
   COV_COR:    cover property (cor_rd ##1 req_reg.rd);
   COV_WAVE:   cover property (wave_strobe_o);
endmodule : aea_core

// [test/active_energy_accumulator_test.sv]
// Purpose: self-checking bench for the active energy accumulator
// Assumes: wave base period shortened to 8 cycles
// Notes:   test powers land on whole energy lsbs except the 0x7FF trim case, which truncates 11.998 lsbs to 0xB
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   begin \
      samples_checked++; \
      if ((g) !== (e)) \
      begin \
         n_errors++; \
         $display("[ERR] %s expected %h seen %h", nm, e, g); \
      end \
   end
module active_energy_accumulator_test;
   localparam int WB = 8;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        frequency_output_pulse_i = 1'b0;
   logic [23:0] power_i = 24'h0;
   logic        hsel_i;
   logic        hwrite_i;
   logic        hreadyout_o;
   logic        hresp_o;
   logic        irq_o;
   logic        wave_strobe_o;
   logic [1:0]  htrans_i;
   logic [2:0]  hsize_i;
   logic [31:0] haddr_i;
   logic [31:0] hwdata_i;
   logic [31:0] hrdata_o;
   logic [23:0] wave_data_o;
   int          n_errors = 0;
   int          samples_checked = 0;
   always #12.5 clk_i = ~clk_i;
   aea_core #(.WAVE_BASE_CYC(WB)) i_dut (.clk_i, .rst_n_i, .hsel_i,
      .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
      .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .power_i, .frequency_output_pulse_i, .irq_o, .wave_data_o,
      .wave_strobe_o);
   aea_cpu_model i_cpu (.clk_i, .hready_i(hreadyout_o),
      .hrdata_i(hrdata_o), .hsel_o(hsel_i), .haddr_o(haddr_i),
      .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i),
      .hwdata_o(hwdata_i));
   ////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      i_cpu.xfer(1'b1, idx, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] idx,
                     input logic [31:0] e);
      logic [31:0] q;
      i_cpu.xfer(1'b0, idx, 32'h0, q);
      `CHK(nm, e, q)
   endtask : rd
   task automatic pw(input logic [23:0] p, input int n);
      power_i <= p;
      repeat (5 * n) @(posedge clk_i);
   endtask : pw
   // clear, apply two powers, settle, then read the energy
   task automatic en(input logic [23:0] p1, input int n1,
                     input logic [23:0] p2, input int n2,
                     input logic [31:0] e);
      logic [31:0] q;
      i_cpu.xfer(1'b0, aea_pkg::IDX_ENG_COR, 32'h0, q);
      pw(p1, n1);
      if (n2 > 0)
         pw(p2, n2);
      pw(24'h0, 1);
      rd("energy", aea_pkg::IDX_ENG, e);
   endtask : en
   task automatic ws(output int n);
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (wave_strobe_o !== 1'b1 && n < 200);
   endtask : ws
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] ix [13] = '{8'h0D, 8'h0E, 8'h0F, 8'h1B, 8'hD9, 8'hDB,
         8'hDC, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'h00};
      `CHK("irq", 32'h0, {31'h0, irq_o})
      for (int k = 0; k < 13; k++)
         rd("reset value", ix[k], 32'h0);
      wr(aea_pkg::IDX_SCALE, 32'hFFFFFFFF);
      wr(aea_pkg::IDX_OFS, 32'hFFFFFFFF);
      wr(aea_pkg::IDX_DIV, 32'hFFFFFFFF);
      wr(aea_pkg::IDX_ENG, 32'hFFFFFFFF);
      wr(8'h00, 32'hFFFFFFFF);
      rd("scale", aea_pkg::IDX_SCALE, 32'hFFF);
      rd("offset", aea_pkg::IDX_OFS, 32'hFFFF);
      rd("divider", aea_pkg::IDX_DIV, 32'hFF);
      rd("energy ro", aea_pkg::IDX_ENG, 32'h0);
      rd("unmapped", 8'h00, 32'h0);
      `CHK("hresp", 32'h0, {31'h0, hresp_o})
      `CHK("hready", 32'h1, {31'h0, hreadyout_o})
      wr(aea_pkg::IDX_SCALE, 32'h0);
      wr(aea_pkg::IDX_OFS, 32'h0);
      wr(aea_pkg::IDX_DIV, 32'h0);
      $display("reset and register test done");
   endtask : t_reset
   // +3 ticks then -5 ticks of one energy lsb each
   task automatic t_accum();
      logic [7:0]  md [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
      logic [31:0] ex [4] = '{32'hFFFFFE, 32'h3, 32'h3, 32'h8};
      for (int k = 0; k < 4; k++)
      begin
         wr(aea_pkg::IDX_ACCM, {24'h0, md[k]});
         en(24'h020000, 3, 24'hFE0000, 5, ex[k]);
      end
      rd("plain again", aea_pkg::IDX_ENG, 32'h8);
      rd("clear on read", aea_pkg::IDX_ENG_COR, 32'h8);
      rd("after clear", aea_pkg::IDX_ENG, 32'h0);
      wr(aea_pkg::IDX_ACCM, 32'h0);
      $display("accumulation mode test done");
   endtask : t_accum
   task automatic t_path();
      wr(aea_pkg::IDX_DIV, 32'h2);
      en(24'h040000, 3, 24'h0, 0, 32'h3);
      wr(aea_pkg::IDX_DIV, 32'h0);
      wr(aea_pkg::IDX_SCALE, 32'h800);
      en(24'h040000, 3, 24'h0, 0, 32'h3);
      wr(aea_pkg::IDX_SCALE, 32'h7FF);
      en(24'h020000, 8, 24'h0, 0, 32'hB);
      wr(aea_pkg::IDX_SCALE, 32'h0);
      // offset last: idle ticks then leave small low-order residue
      wr(aea_pkg::IDX_OFS, 32'h100);
      en(24'h01FFFF, 4, 24'h0, 0, 32'h4);
      wr(aea_pkg::IDX_OFS, 32'h0);
      $display("power path test done");
   endtask : t_path
   task automatic t_sign();
      wr(aea_pkg::IDX_IEN_L, 32'h1);
      wr(aea_pkg::IDX_IST_L, 32'hF);
      pw(24'h000100, 2);
      pw(24'hFFFF00, 2);
      rd("pos to neg", aea_pkg::IDX_IST_L, 32'h1);
      `CHK("irq set", 32'h1, {31'h0, irq_o})
      pw(24'h0, 1);
      wr(aea_pkg::IDX_IST_L, 32'h1);
      rd("cleared", aea_pkg::IDX_IST_L, 32'h0);
      `CHK("irq clear", 32'h0, {31'h0, irq_o})
      wr(aea_pkg::IDX_ACCM, 32'h4);
      pw(24'hFFFF00, 2);
      rd("dir ignores", aea_pkg::IDX_IST_L, 32'h0);
      pw(24'h0, 2);
      rd("neg to pos", aea_pkg::IDX_IST_L, 32'h1);
      wr(aea_pkg::IDX_ACCM, 32'h0);
      wr(aea_pkg::IDX_GAIN, 32'h80);
      wr(aea_pkg::IDX_IST_L, 32'h1);
      pw(24'h000100, 1);
      frequency_output_pulse_i <= 1'b1;
      pw(24'h000100, 1);
      frequency_output_pulse_i <= 1'b0;
      pw(24'hFFFF00, 4);
      rd("no pulse", aea_pkg::IDX_IST_L, 32'h0);
      frequency_output_pulse_i <= 1'b1;
      pw(24'hFFFF00, 1);
      frequency_output_pulse_i <= 1'b0;
      pw(24'h0, 1);
      rd("on pulse", aea_pkg::IDX_IST_L, 32'h1);
      wr(aea_pkg::IDX_GAIN, 32'h0);
      wr(aea_pkg::IDX_IST_L, 32'hF);
      $display("sign change test done");
   endtask : t_sign
   task automatic t_noload();
      int th [3] = '{8388607 * 150 / 1000000, 8388607 * 75 / 1000000,
                     8388607 * 37 / 1000000};
      wr(aea_pkg::IDX_IEN_L, 32'h2);
      for (int c = 1; c < 4; c++)
      begin
         wr(aea_pkg::IDX_NL, 32'(c));
         pw(24'(th[c - 1] + 1), 2);
         wr(aea_pkg::IDX_IST_L, 32'hF);
         rd("above", aea_pkg::IDX_IST_L, 32'h0);
         pw(24'(th[c - 1] - 1), 2);
         rd("below", aea_pkg::IDX_IST_L, 32'h2);
         `CHK("irq", 32'h1, {31'h0, irq_o})
      end
      wr(aea_pkg::IDX_NL, 32'h0);
      wr(aea_pkg::IDX_IST_L, 32'hF);
      rd("disabled", aea_pkg::IDX_IST_L, 32'h0);
      wr(aea_pkg::IDX_NL, 32'h1);
      // without the gate 200 ticks would reach one lsb
      en(24'd1257, 200, 24'h0, 0, 32'h0);
      wr(aea_pkg::IDX_NL, 32'h0);
      wr(aea_pkg::IDX_IEN_L, 32'h0);
      wr(aea_pkg::IDX_IST_L, 32'hF);
      $display("no-load test done");
   endtask : t_noload
   task automatic t_wave();
      int n;
      power_i <= 24'h123456;
      wr(aea_pkg::IDX_IEN_H, 32'h1);
      for (int r = 0; r < 4; r++)
      begin
         wr(aea_pkg::IDX_WAVE, 32'(r << 2));
         ws(n);
         ws(n);
         `CHK("wave period", 32'(WB << r), 32'(n))
         `CHK("wave data", 32'h123456, {8'h0, wave_data_o})
      end
      wr(aea_pkg::IDX_WAVE, 32'h1);
      ws(n);
      `CHK("other source", 32'd200, 32'(n))
      wr(aea_pkg::IDX_WAVE, 32'h0);
      wr(aea_pkg::IDX_IEN_H, 32'h0);
      ws(n);
      `CHK("disabled", 32'd200, 32'(n))
      power_i <= 24'h0;
      $display("waveform test done");
   endtask : t_wave
   ////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", samples_checked,
               n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_accum();
      t_path();
      t_sign();
      t_noload();
      t_wave();
      complete_run();
   end
   // whole run needs well under 10000 cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      complete_run();
   end
endmodule : active_energy_accumulator_test

// [test/aea_cpu_model.sv]
// Purpose: processor-side register master facing the energy block
// Assumes: single aligned word transfers, one slave drives hready
// Notes:   caller enters xfer right after a rising clock edge
`timescale 1ns/10ps
module aea_cpu_model (
   input  wire logic        clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic             hsel_o,
   output logic      [31:0] haddr_o,
   output logic      [1:0]  htrans_o,
   output logic             hwrite_o,
   output logic      [2:0]  hsize_o,
   output logic      [31:0] hwdata_o
);
   initial
   begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
      hsel_o   <= 1'b1;
      haddr_o  <= {22'h0, idx, 2'h0};
      htrans_o <= 2'h2;
      hwrite_o <= w;
      // stale write data is inverted so it never looks valid
      hwdata_o <= ~hwdata_o;
      @(posedge clk_i);
      while (hready_i !== 1'b1)
         @(posedge clk_i);
      hsel_o   <= 1'b0;
      htrans_o <= 2'h0;
      hwdata_o <= d;
      @(posedge clk_i);
      while (hready_i !== 1'b1)
         @(posedge clk_i);
      q = hrdata_i;
   endtask : xfer
endmodule : aea_cpu_model
